// *** shared/cdt8_pkg.sv ***
package cdt8_pkg;
   // control register field layout
   localparam int CLK_SEL_LSB = 4;
   localparam int CLK_SEL_W = 3;
   localparam int RUN_BIT = 3;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 3;
   localparam int FF_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_MAX = 8'hff;

   typedef enum logic [2:0] {
      CDT8_MODE_TIMER8 = 3'h0,
      CDT8_MODE_DIV8 = 3'h1,
      CDT8_MODE_PWM8 = 3'h2,
      CDT8_MODE_RSVD = 3'h3,
      CDT8_MODE_TIMER16 = 3'h4,
      CDT8_MODE_WARMUP = 3'h5,
      CDT8_MODE_PWM16 = 3'h6,
      CDT8_MODE_PULSEGEN = 3'h7
   } cdt8_mode_t;

   localparam logic [2:0] CLK_SEL_DIV2048 = 3'h0;
   localparam logic [2:0] CLK_SEL_DIV128 = 3'h1;
   localparam logic [2:0] CLK_SEL_DIV32 = 3'h2;
   localparam logic [2:0] CLK_SEL_DIV8 = 3'h3;
   localparam logic [2:0] CLK_SEL_FS = 3'h4;
   localparam logic [2:0] CLK_SEL_DIV2 = 3'h5;
   localparam logic [2:0] CLK_SEL_FC = 3'h6;
   localparam logic [2:0] CLK_SEL_PIN = 3'h7;

   // prescaler tap positions (log2 of divide ratio)
   localparam int TAP_2048 = 11;
   localparam int TAP_128 = 7;
   localparam int TAP_32 = 5;
   localparam int TAP_8 = 3;
   localparam int TAP_2 = 1;
   localparam int PRESCALE_W = 12;
   localparam int FS_DIV8_W = 3;
endpackage

// *** shared/cdt8_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cdt8_tick_if;
   logic tick_2048;
   logic tick_128;
   logic tick_32;
   logic tick_8;
   logic tick_2;
   logic tick_fs;
   logic tick_fs8;
   modport src (output tick_2048, tick_128, tick_32, tick_8, tick_2, tick_fs, tick_fs8);
   modport dst (input tick_2048, tick_128, tick_32, tick_8, tick_2, tick_fs, tick_fs8);
endinterface
`default_nettype wire

// *** hdl/cdt8_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdt8_prescaler (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_fs_tick,
   cdt8_tick_if.src tk
);
   logic [cdt8_pkg::PRESCALE_W-1:0] div_ff;
   logic [cdt8_pkg::PRESCALE_W-1:0] nxt_div;
   logic [cdt8_pkg::FS_DIV8_W-1:0] fs_ff;
   logic [cdt8_pkg::FS_DIV8_W-1:0] nxt_fs;

   // free-running divider; taps are one-cycle enables on wrap
   always_comb begin
      nxt_div = div_ff + 1'b1;
      nxt_fs = i_fs_tick ? fs_ff + 1'b1 : fs_ff;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         div_ff <= '0;
         fs_ff <= '0;
      end else begin
         div_ff <= nxt_div;
         fs_ff <= nxt_fs;
      end
   end

   assign tk.tick_2048 = &div_ff[cdt8_pkg::TAP_2048-1:0];
   assign tk.tick_128 = &div_ff[cdt8_pkg::TAP_128-1:0];
   assign tk.tick_32 = &div_ff[cdt8_pkg::TAP_32-1:0];
   assign tk.tick_8 = &div_ff[cdt8_pkg::TAP_8-1:0];
   assign tk.tick_2 = &div_ff[cdt8_pkg::TAP_2-1:0];
   assign tk.tick_fs = i_fs_tick;
   assign tk.tick_fs8 = i_fs_tick & (&fs_ff);
endmodule
`default_nettype wire

// *** hdl/cdt8_dual_timer.sv ***
// Operation
// - units offer 8-bit and cascaded 16-bit modes
// - lower and upper counters chain into 16
// - timer counts on each selected tick
// - match raises irq and clears counter
// - counting resumes from zero automatically
// - compare value takes effect immediately
// - tick sources per speed state and tap
// - control bit layout clock run mode
// - mode field: only upper bit 2 decoded, 1xx cascades
// - upper 16-bit mode clocks on lower overflow
// - run clear stops and zeroes counter; in cascade the upper run bit rules both
`timescale 1ns/1ps
`default_nettype none
module cdt8_dual_timer #(
   parameter int CNT_W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_fs_tick,
   input wire logic i_slow_state,
   input wire logic i_divider_tap_select,
   input wire logic i_lower_pin_event,
   input wire logic i_upper_pin_event,
   input wire logic i_lower_ctrl_we,
   input wire logic [7:0] i_lower_ctrl_wdata,
   input wire logic i_upper_ctrl_we,
   input wire logic [7:0] i_upper_ctrl_wdata,
   input wire logic i_lower_cmp_we,
   input wire logic [CNT_W-1:0] i_lower_cmp_wdata,
   input wire logic i_upper_cmp_we,
   input wire logic [CNT_W-1:0] i_upper_cmp_wdata,
   output logic [7:0] o_lower_control_reg,
   output logic [7:0] o_upper_control_reg,
   output logic [CNT_W-1:0] o_lower_match_period_reg,
   output logic [CNT_W-1:0] o_upper_match_period_reg,
   output logic [CNT_W-1:0] o_lower_count,
   output logic [CNT_W-1:0] o_upper_count,
   output logic o_lower_match_irq,
   output logic o_upper_match_irq
);
   cdt8_tick_if tk ();

   cdt8_prescaler u_pre (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_fs_tick(i_fs_tick),
      .tk(tk)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // control and compare registers

   logic [7:0] ctrl_ff [2];
   logic [7:0] nxt_ctrl [2];
   logic [CNT_W-1:0] cmp_ff [2];
   logic [CNT_W-1:0] nxt_cmp [2];
   logic [CNT_W-1:0] cnt_ff [2];
   logic [CNT_W-1:0] nxt_cnt [2];
   logic irq_ff [2];
   logic nxt_irq [2];
   logic tick [2];
   logic ovf_lower;
   logic cascade;

   always_comb begin
      nxt_ctrl[0] = i_lower_ctrl_we ? i_lower_ctrl_wdata : ctrl_ff[0];
      nxt_ctrl[1] = i_upper_ctrl_we ? i_upper_ctrl_wdata : ctrl_ff[1];
      // no buffer stage: compare used at once
      nxt_cmp[0] = i_lower_cmp_we ? i_lower_cmp_wdata : cmp_ff[0];
      nxt_cmp[1] = i_upper_cmp_we ? i_upper_cmp_wdata : cmp_ff[1];
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ctrl_ff[0] <= cdt8_pkg::CTRL_RESET;
         ctrl_ff[1] <= cdt8_pkg::CTRL_RESET;
         cmp_ff[0] <= CNT_W'(cdt8_pkg::CMP_RESET);
         cmp_ff[1] <= CNT_W'(cdt8_pkg::CMP_RESET);
      end else begin
         ctrl_ff[0] <= nxt_ctrl[0];
         ctrl_ff[1] <= nxt_ctrl[1];
         cmp_ff[0] <= nxt_cmp[0];
         cmp_ff[1] <= nxt_cmp[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // tick selection

   function automatic logic sel_tick(input logic [2:0] sel, input logic pin);
      logic t;
      t = 1'b0;
      case (sel)
         cdt8_pkg::CLK_SEL_DIV2048: begin
            // slow states or tap select give fs/8
            t = (i_slow_state || i_divider_tap_select) ? tk.tick_fs8 : tk.tick_2048;
         end
         cdt8_pkg::CLK_SEL_DIV128: t = i_slow_state ? 1'b0 : tk.tick_128;
         cdt8_pkg::CLK_SEL_DIV32: t = i_slow_state ? 1'b0 : tk.tick_32;
         cdt8_pkg::CLK_SEL_DIV8: t = i_slow_state ? 1'b0 : tk.tick_8;
         cdt8_pkg::CLK_SEL_FS: t = tk.tick_fs;
         cdt8_pkg::CLK_SEL_DIV2: t = i_slow_state ? 1'b0 : tk.tick_2;
         cdt8_pkg::CLK_SEL_FC: t = ~i_slow_state;
         cdt8_pkg::CLK_SEL_PIN: t = pin;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   logic [2:0] mode_up;
   assign mode_up = ctrl_ff[1][cdt8_pkg::MODE_LSB +: cdt8_pkg::MODE_W];
   // upper mode 1xx: 16-bit cascade
   assign cascade = mode_up[cdt8_pkg::MODE_W-1];

   always_comb begin
      // in cascade, lower clock select picks the shared source
      tick[0] = sel_tick(ctrl_ff[0][cdt8_pkg::CLK_SEL_LSB +: cdt8_pkg::CLK_SEL_W],
                         i_lower_pin_event);
      // upper counter steps on lower overflow when cascaded
      ovf_lower = tick[0] && (cnt_ff[0] == CNT_W'(cdt8_pkg::CNT_MAX));
      tick[1] = cascade ? ovf_lower
              : sel_tick(ctrl_ff[1][cdt8_pkg::CLK_SEL_LSB +: cdt8_pkg::CLK_SEL_W],
                         i_upper_pin_event);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counters

   logic run [2];
   logic match [2];
   logic match16;

   always_comb begin
      run[0] = cascade ? ctrl_ff[1][cdt8_pkg::RUN_BIT] : ctrl_ff[0][cdt8_pkg::RUN_BIT];
      run[1] = ctrl_ff[1][cdt8_pkg::RUN_BIT];
      match[0] = tick[0] && (cnt_ff[0] == cmp_ff[0]);
      match[1] = tick[1] && (cnt_ff[1] == cmp_ff[1]);
      // 16-bit match on full pair at lower tick
      match16 = tick[0] && (cnt_ff[0] == cmp_ff[0]) && (cnt_ff[1] == cmp_ff[1]);
      for (int i = 0; i < 2; i++) begin
         nxt_cnt[i] = cnt_ff[i];
         nxt_irq[i] = 1'b0;
      end
      if (cascade) begin
         if (!run[1]) begin
            nxt_cnt[0] = CNT_W'(cdt8_pkg::CNT_ZERO);
            nxt_cnt[1] = CNT_W'(cdt8_pkg::CNT_ZERO);
         end else if (match16) begin
            nxt_cnt[0] = CNT_W'(cdt8_pkg::CNT_ZERO);
            nxt_cnt[1] = CNT_W'(cdt8_pkg::CNT_ZERO);
            nxt_irq[1] = 1'b1;
         end else if (tick[0]) begin
            nxt_cnt[0] = cnt_ff[0] + CNT_W'(cdt8_pkg::CNT_ONE);
            if (ovf_lower) begin
               nxt_cnt[1] = cnt_ff[1] + CNT_W'(cdt8_pkg::CNT_ONE);
            end
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run[i]) begin
               nxt_cnt[i] = CNT_W'(cdt8_pkg::CNT_ZERO);
            end else if (match[i]) begin
               nxt_cnt[i] = CNT_W'(cdt8_pkg::CNT_ZERO);
               nxt_irq[i] = 1'b1;
            end else if (tick[i]) begin
               // free restart after clear
               nxt_cnt[i] = cnt_ff[i] + CNT_W'(cdt8_pkg::CNT_ONE);
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         for (int i = 0; i < 2; i++) begin
            cnt_ff[i] <= CNT_W'(cdt8_pkg::CNT_ZERO);
            irq_ff[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            cnt_ff[i] <= nxt_cnt[i];
            irq_ff[i] <= nxt_irq[i];
         end
      end
   end

   assign o_lower_control_reg = ctrl_ff[0];
   assign o_upper_control_reg = ctrl_ff[1];
   assign o_lower_match_period_reg = cmp_ff[0];
   assign o_upper_match_period_reg = cmp_ff[1];
   assign o_lower_count = cnt_ff[0];
   assign o_upper_count = cnt_ff[1];
   assign o_lower_match_irq = irq_ff[0];
   assign o_upper_match_irq = irq_ff[1];
endmodule
`default_nettype wire

// *** dv/cdt8_dual_timer_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdt8_dual_timer_sva #(parameter int CNT_W = 8) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_slow_state,
   input wire logic i_lower_ctrl_we,
   input wire logic [7:0] i_lower_ctrl_wdata,
   input wire logic i_lower_cmp_we,
   input wire logic [CNT_W-1:0] i_lower_cmp_wdata,
   input wire logic [7:0] o_lower_control_reg,
   input wire logic [7:0] o_upper_control_reg,
   input wire logic [CNT_W-1:0] o_lower_match_period_reg,
   input wire logic [CNT_W-1:0] o_lower_count,
   input wire logic [CNT_W-1:0] o_upper_count,
   input wire logic o_lower_match_irq,
   input wire logic o_upper_match_irq
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   a_lower_irq_pulse: assert property (o_lower_match_irq |=> !o_lower_match_irq)
      else $error("lower irq held");
   a_upper_irq_pulse: assert property (o_upper_match_irq |=> !o_upper_match_irq)
      else $error("upper irq held");
   a_match_clears: assert property (o_lower_match_irq |-> o_lower_count == '0 &&
      $past(o_lower_count) == $past(o_lower_match_period_reg)) else $error("irq cause");
   a_ctrl_written: assert property (i_lower_ctrl_we |=>
      o_lower_control_reg == $past(i_lower_ctrl_wdata)) else $error("ctrl write");
   a_cmp_immediate: assert property (i_lower_cmp_we |=>
      o_lower_match_period_reg == $past(i_lower_cmp_wdata)) else $error("cmp write");
   a_stop_clears: assert property (!o_lower_control_reg[3] && !$past(o_lower_control_reg[3])
      && !o_upper_control_reg[2] |-> o_lower_count == '0) else $error("stopped count");
   a_count_step: assert property ($changed(o_lower_count) |-> o_lower_count == '0 ||
      o_lower_count == $past(o_lower_count) + 1'b1) else $error("count step");
   a_cascade_carry: assert property (o_upper_control_reg[2] && $past(o_upper_control_reg[2])
      && $changed(o_upper_count) && o_upper_count != '0 |-> $past(o_lower_count) == '1)
      else $error("carry");
   a_slow_gated: assert property (i_slow_state && $past(i_slow_state) &&
      o_lower_control_reg[6:4] == 3'h1 && $stable(o_lower_control_reg) |-> $stable(o_lower_count))
      else $error("slow tick");
   c_lower_irq: cover property (o_lower_match_irq);
   c_cascade_irq: cover property (o_upper_match_irq && o_upper_control_reg[2]);
   c_slow_irq: cover property (i_slow_state && o_lower_match_irq);
endmodule
`default_nettype wire

// *** dv/cdt8_dual_timer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdt8_dual_timer_bench;
   logic i_ref_clk = '0, i_resetn = '0, i_fs_tick = '0, i_slow_state = '0;
   logic i_divider_tap_select = '0, i_lower_pin_event = '0, i_upper_pin_event = '0;
   logic i_lower_ctrl_we = '0, i_upper_ctrl_we = '0, i_lower_cmp_we = '0, i_upper_cmp_we = '0;
   logic [7:0] i_lower_ctrl_wdata = '0, i_upper_ctrl_wdata = '0;
   logic [7:0] i_lower_cmp_wdata = '0, i_upper_cmp_wdata = '0;
   logic [7:0] o_lower_control_reg, o_upper_control_reg, o_lower_match_period_reg;
   logic [7:0] o_upper_match_period_reg, o_lower_count, o_upper_count;
   logic o_lower_match_irq, o_upper_match_irq;
   logic [7:0] cs [9] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h58, 8'h48, 8'h78, 8'h08, 8'h08};
   int per [9] = '{4096, 256, 64, 16, 4, 8, 6, 64, 64};
   int mismatches = 0, n_checks = 0, cyc = 0, n_lo = 0, n, m;
   cdt8_dual_timer dut (.*);
   always #5 i_ref_clk = ~i_ref_clk;
   // free-running tick and pin sources
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      i_fs_tick <= cyc % 4 == 3;
      i_lower_pin_event <= cyc % 3 == 2;
      i_upper_pin_event <= cyc % 5 == 4;
      n_lo <= n_lo + o_lower_match_irq;
      if (cyc == 30000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", s, e, g);
      end
   endtask
   // k: 0 lower ctrl, 1 upper ctrl, 2 lower cmp, 3 upper cmp
   task automatic wr(input int k, input logic [7:0] d);
      @(posedge i_ref_clk);
      {i_lower_ctrl_wdata, i_upper_ctrl_wdata, i_lower_cmp_wdata, i_upper_cmp_wdata} <= {4{d}};
      {i_upper_cmp_we, i_lower_cmp_we, i_upper_ctrl_we, i_lower_ctrl_we} <= 4'h1 << k;
      @(posedge i_ref_clk);
      {i_upper_cmp_we, i_lower_cmp_we, i_upper_ctrl_we, i_lower_ctrl_we} <= 4'h0;
   endtask
   task automatic wirq(input bit up, output int k);
      k = 0;
      do begin
         @(posedge i_ref_clk);
         #1;
         k++;
      end while ((up ? o_upper_match_irq : o_lower_match_irq) !== 1'b1 && k < 9000);
   endtask
   task automatic prd(input bit up, input int e);
      wirq(up, n);
      wirq(up, n);
      chk("period", e, n);
   endtask
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      #1;
      chk("ctrl", 8'h00, o_lower_control_reg);
      chk("count", 8'h00, o_upper_count);
      wr(2, 8'h02);
      wr(0, 8'h68);
      wirq(0, n);
      chk("latency", 3, n);
      prd(0, 3);
      for (int c = 1; c < 256; c += 127) begin
         wr(0, 8'h60);
         wr(2, c[7:0]);
         wr(0, 8'h68);
         prd(0, c + 1);
      end
      wr(2, 8'h01);
      for (int i = 0; i < 9; i++) begin
         wr(0, o_lower_control_reg & 8'hf7);
         i_divider_tap_select <= i == 7;
         i_slow_state <= i == 8;
         wr(0, cs[i] & 8'hf7);
         wr(0, cs[i]);
         prd(0, per[i]);
      end
      wr(0, 8'h00);
      wr(0, 8'h10);
      wr(0, 8'h18);
      repeat (300) @(posedge i_ref_clk);
      #1;
      chk("slow", 8'h00, o_lower_count);
      i_slow_state <= 1'b0;
      wr(0, 8'h10);
      wr(2, 8'hff);
      wr(0, 8'h60);
      wr(0, 8'h68);
      repeat (20) @(posedge i_ref_clk);
      wr(0, 8'h60);
      @(posedge i_ref_clk);
      #1;
      chk("stop", 8'h00, o_lower_count);
      wr(2, 8'h01);
      wr(3, 8'h01);
      #1;
      chk("upper cmp", 8'h01, o_upper_match_period_reg);
      wr(1, 8'h04);
      #1;
      chk("upper ctrl", 8'h04, o_upper_control_reg);
      wr(0, 8'h63);
      m = n_lo;
      wr(1, 8'h0c);
      prd(1, 258);
      chk("lower irq", m, n_lo);
      tally_and_finish();
   end
endmodule
bind cdt8_dual_timer cdt8_dual_timer_sva #(.CNT_W(CNT_W)) sva (.*);
`default_nettype wire
